/* common/ccr_regs.svh */
// register offsets, field positions and reset values of the code and config bank
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH

// register offsets
`define CCR_ADDR_CH2 8'h19
`define CCR_ADDR_CH0 8'h1B
`define CCR_ADDR_CH1 8'h1C
`define CCR_ADDR_CFG 8'h1F
`define CCR_ADDR_TRIG 8'h20

// reset values
`define CCR_CFG_RST 16'h0FFF
`define CCR_CODE_RST 12'h000

// channel code field, stored bits and the 10-bit code inside them
`define CCR_CODE_HI 15
`define CCR_CODE_LO 4
`define CCR_CODE_MSB 11
`define CCR_CODE_LSB 2

// shared configuration fields
`define CCR_LATCH_BIT 15
`define CCR_LOCK_BIT 14
`define CCR_FAULT_BIT 13
`define CCR_IREF_BIT 12
`define CCR_CH1_PWR_HI 11
`define CCR_CH1_PWR_LO 10
`define CCR_CH0_PWR_HI 8
`define CCR_CH0_PWR_LO 7
`define CCR_CH2_PWR_HI 2
`define CCR_CH2_PWR_LO 1
`define CCR_CH2_PWR_UP 2'h0

// unlock field of the trigger register
`define CCR_UNLOCK_HI 15
`define CCR_UNLOCK_LO 12
`define CCR_UNLOCK_CODE 4'h5

`endif

/* common/ccr_pkg.sv */
// types shared by the code and config register bank
package ccr_pkg;

   // four-state power mode of channels 0 and 1
   typedef enum logic [1:0]
   {
      PWR_UP = 2'h0,
      PWR_DN_10K = 2'h1,
      PWR_DN_100K = 2'h2,
      PWR_DN_HIZ = 2'h3
   } ccr_pwr_t;

   // lock sequencer states, gray along open -> shut -> armed
   typedef enum logic [1:0]
   {
      LK_OPEN = 2'h0,
      LK_SHUT = 2'h1,
      LK_ARMED = 2'h3
   } ccr_lock_st_t;

   // one register access from the serial front end
   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } ccr_req_t;

   // decoded configuration handed to the converter
   typedef struct packed
   {
      logic latch_sel;
      logic lock;
      logic fault_sel;
      logic int_ref_en;
      ccr_pwr_t ch1_pwr;
      ccr_pwr_t ch0_pwr;
      logic [1:0] ch2_pwr;
      logic ch2_down;
   } ccr_cfg_t;

endpackage

/* core/ccr_lock_ctrl.sv */
// lock, arm and unlock sequencer guarding register writes
`timescale 1ns/100ps
module ccr_lock_ctrl
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // write strobes, unlock match and the lock bit of the write data
   input wire logic wr_en,
   input wire logic trig_wr,
   input wire logic cfg_wr,
   input wire logic unlock_ok,
   input wire logic lock_val,
   // write permission and state
   output logic wr_ok,
   output logic locked
);

   ccr_pkg::ccr_lock_st_t state_r;
   ccr_pkg::ccr_lock_st_t state_nxt;

   // next state of the lock sequencer
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ccr_pkg::LK_OPEN:
         begin
            if (cfg_wr && lock_val)
               state_nxt = ccr_pkg::LK_SHUT;
         end
         ccr_pkg::LK_SHUT:
         begin
            if (trig_wr && unlock_ok)
               state_nxt = ccr_pkg::LK_ARMED;
         end
         ccr_pkg::LK_ARMED:
         begin
            if (cfg_wr && !lock_val)
               state_nxt = ccr_pkg::LK_OPEN;
            else if (trig_wr && unlock_ok)
               state_nxt = ccr_pkg::LK_ARMED;
            else if (wr_en)
               state_nxt = ccr_pkg::LK_SHUT;
         end
         default:
            state_nxt = ccr_pkg::LK_SHUT;
      endcase
   end

   // state register, open after reset
   always_ff @(posedge clk)
   begin
      if (rst)
         state_r <= ccr_pkg::LK_OPEN;
      else
         state_r <= state_nxt;
   end

   // writes pass while open, or the single clearing write once armed
   always_comb
   begin
      wr_ok = (state_r == ccr_pkg::LK_OPEN) ||
              (state_r == ccr_pkg::LK_ARMED && cfg_wr && !lock_val);
      locked = (state_r != ccr_pkg::LK_OPEN);
   end

endmodule // ccr_lock_ctrl

/* core/ccr_cfg_regs.sv */
// channel code registers and shared configuration register of the converter
`timescale 1ns/100ps
`include "ccr_regs.svh"
// Summary of operation
// - code registers hold a left-aligned straight-binary code; low four bits ignored
// - config bit 15 picks latching or non-latching comparator output, resets 0
// - lock bit 14 set blocks every code and config register write except the clearing write once armed, trigger writes still pass; resets to 0
// - lock clears only by unlock code write followed by writing lock as 0
// - unlock field is trigger bits 15..12; pattern 0101 unlocks, others ignored
// - bit 13 selects fault-dump read at address 0x00 or 0x01, resets 0
// - bit 12 enables internal reference, resets 0; host sets it before gains
// - channel 1 power bits 11..10: up, 10k, 100k, high impedance; reset 3
// - channel 0 power bits 8..7 use the same four modes; reset 3
// - channel 2 power bits 2..1: 00 up, else 1.2k pull-down; reset 3
module ccr_cfg_regs
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register access port
   input wire ccr_pkg::ccr_req_t req,
   output logic [15:0] rd_data,
   output logic rd_valid,
   output logic wr_refused,
   // converter controls
   output logic [2:0][9:0] chan_code,
   output ccr_pkg::ccr_cfg_t cfg
);

   localparam logic [7:0] CODE_ADDR [3] = '{`CCR_ADDR_CH0, `CCR_ADDR_CH1, `CCR_ADDR_CH2};

   logic [15:0] cfg_r;
   logic [11:0] code_r [3];
   logic [15:0] rd_data_r;
   logic [15:0] rd_data_nxt;
   logic rd_valid_r;
   logic wr_refused_r;
   logic ch2_down_r;
   logic trig_hit;
   logic cfg_hit;
   logic map_hit;
   logic wr_ok;
   logic locked;
   logic unlock_ok;
   logic cfg_take;

   // address compare shared by write and read decoding
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
      hit = (a == ref_a);
   endfunction

   // write strobe decode
   always_comb
   begin
      trig_hit = req.wr && hit(req.addr, `CCR_ADDR_TRIG);
      cfg_hit = req.wr && hit(req.addr, `CCR_ADDR_CFG);
      map_hit = hit(req.addr, `CCR_ADDR_CFG) || hit(req.addr, CODE_ADDR[0]) ||
                hit(req.addr, CODE_ADDR[1]) || hit(req.addr, CODE_ADDR[2]);
      unlock_ok = (req.wdata[`CCR_UNLOCK_HI:`CCR_UNLOCK_LO] == `CCR_UNLOCK_CODE);
      cfg_take = cfg_hit && wr_ok;
   end

   // lock sequencer
   ccr_lock_ctrl u_lock
   (
      .clk(ref_clk),
      .rst(rst),
      .wr_en(req.wr),
      .trig_wr(trig_hit),
      .cfg_wr(cfg_hit),
      .unlock_ok(unlock_ok),
      .lock_val(req.wdata[`CCR_LOCK_BIT]),
      .wr_ok(wr_ok),
      .locked(locked)
   );

   // shared configuration word, whole word taken on a permitted write
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         cfg_r <= `CCR_CFG_RST;
      else if (cfg_take)
         cfg_r <= req.wdata;
   end

   // channel 2 power-down flag kept as its own flop
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         ch2_down_r <= 1'b1;
      else if (cfg_take)
         ch2_down_r <= (req.wdata[`CCR_CH2_PWR_HI:`CCR_CH2_PWR_LO] != `CCR_CH2_PWR_UP);
   end

   // one code register per channel, low nibble dropped
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_code
         always_ff @(posedge ref_clk)
         begin
            if (rst)
               code_r[gi] <= `CCR_CODE_RST;
            else if (req.wr && hit(req.addr, CODE_ADDR[gi]) && wr_ok)
               code_r[gi] <= req.wdata[`CCR_CODE_HI:`CCR_CODE_LO];
         end
         assign chan_code[gi] = code_r[gi][`CCR_CODE_MSB:`CCR_CODE_LSB];
         // a permitted write lands in this channel, a refused one leaves it alone
         a_code_take: assert property (@(posedge ref_clk) disable iff (rst)
            req.wr && hit(req.addr, CODE_ADDR[gi]) && wr_ok
            |=> code_r[gi] == $past(req.wdata[`CCR_CODE_HI:`CCR_CODE_LO]))
            else $error("code register did not take a permitted write");
         a_code_guard: assert property (@(posedge ref_clk) disable iff (rst)
            req.wr && hit(req.addr, CODE_ADDR[gi]) && !wr_ok
            |=> $stable(code_r[gi]) && wr_refused)
            else $error("code register changed on a refused write");
      end
   endgenerate

   // read data select, unmapped and trigger addresses read zero
   always_comb
   begin
      rd_data_nxt = 16'h0000;
      if (hit(req.addr, `CCR_ADDR_CFG))
         rd_data_nxt = cfg_r;
      else if (hit(req.addr, CODE_ADDR[0]))
         rd_data_nxt = {code_r[0], 4'h0};
      else if (hit(req.addr, CODE_ADDR[1]))
         rd_data_nxt = {code_r[1], 4'h0};
      else if (hit(req.addr, CODE_ADDR[2]))
         rd_data_nxt = {code_r[2], 4'h0};
   end

   // read answer one cycle after the request
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rd_data_r <= 16'h0000;
         rd_valid_r <= 1'b0;
      end
      else
      begin
         rd_valid_r <= req.rd;
         if (req.rd)
            rd_data_r <= rd_data_nxt;
      end
   end

   // flags a write that the lock or the decode threw away
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         wr_refused_r <= 1'b0;
      else
         wr_refused_r <= req.wr && !trig_hit && (!wr_ok || !map_hit);
   end

   // outputs straight from the register flops
   assign rd_data = rd_data_r;
   assign rd_valid = rd_valid_r;
   assign wr_refused = wr_refused_r;
   assign cfg.latch_sel = cfg_r[`CCR_LATCH_BIT];
   assign cfg.lock = cfg_r[`CCR_LOCK_BIT];
   assign cfg.fault_sel = cfg_r[`CCR_FAULT_BIT];
   assign cfg.int_ref_en = cfg_r[`CCR_IREF_BIT];
   assign cfg.ch1_pwr = ccr_pkg::ccr_pwr_t'(cfg_r[`CCR_CH1_PWR_HI:`CCR_CH1_PWR_LO]);
   assign cfg.ch0_pwr = ccr_pkg::ccr_pwr_t'(cfg_r[`CCR_CH0_PWR_HI:`CCR_CH0_PWR_LO]);
   assign cfg.ch2_pwr = cfg_r[`CCR_CH2_PWR_HI:`CCR_CH2_PWR_LO];
   assign cfg.ch2_down = ch2_down_r;

   // checks on the register behaviour
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // locked, then unlock code written, then lock written as zero
   sequence s_arm;
      locked && trig_hit && unlock_ok;
   endsequence

   sequence s_clear;
      cfg_hit && !req.wdata[`CCR_LOCK_BIT];
   endsequence

   sequence s_bad_arm;
      locked && trig_hit && !unlock_ok;
   endsequence

   sequence s_relock;
      cfg_hit && req.wdata[`CCR_LOCK_BIT];
   endsequence

   sequence s_other_wr;
      req.wr && !trig_hit && !cfg_hit;
   endsequence

   a_code_write: assert property (
      (req.wr && hit(req.addr, `CCR_ADDR_CH0) && wr_ok)
      |=> chan_code[0] == $past(req.wdata[15:6]) && code_r[0][1:0] == $past(req.wdata[5:4]))
      else $error("channel 0 code not taken from bits 15..6");

   a_code_readback: assert property (
      req.rd && hit(req.addr, `CCR_ADDR_CH1)
      |=> rd_valid && rd_data[3:0] == 4'h0 && rd_data[15:6] == $past(chan_code[1]))
      else $error("channel 1 readback wrong or low nibble not zero");

   a_latch_reset: assert property (
      $past(rst) |-> !cfg.latch_sel && !cfg.lock && !cfg.fault_sel && !cfg.int_ref_en)
      else $error("config single-bit fields not zero after reset");

   a_latch_write: assert property (
      cfg_take |=> cfg.latch_sel == $past(req.wdata[15]))
      else $error("comparator latch select not written");

   a_lock_holds: assert property (
      locked && req.wr && hit(req.addr, `CCR_ADDR_CH2)
      |=> $stable(chan_code[2]) && wr_refused)
      else $error("code register changed while locked");

   a_lock_mirror: assert property (
      cfg.lock == locked)
      else $error("lock bit and lock state disagree");

   a_unlock_seq: assert property (
      s_arm ##1 s_clear |=> !cfg.lock && !locked)
      else $error("unlock sequence did not clear the lock");

   a_clear_needs_arm: assert property (
      (locked && $past(locked && req.wr && !(trig_hit && unlock_ok))) and s_clear
      |=> cfg.lock && wr_refused)
      else $error("lock cleared without unlock code");

   a_wrong_code: assert property (
      s_bad_arm ##1 s_clear |=> cfg.lock)
      else $error("lock cleared after a wrong unlock code");

   a_fault_sel: assert property (
      cfg_take |=> cfg.fault_sel == $past(req.wdata[13]))
      else $error("fault dump read select not written");

   a_int_ref: assert property (
      cfg_take |=> cfg.int_ref_en == $past(req.wdata[12]))
      else $error("internal reference enable not written");

   a_ch1_pwr: assert property (
      cfg_take |=> cfg.ch1_pwr == $past(req.wdata[11:10]))
      else $error("channel 1 power mode not written");

   a_ch0_pwr: assert property (
      cfg_take |=> cfg.ch0_pwr == $past(req.wdata[8:7]))
      else $error("channel 0 power mode not written");

   a_pwr_reset: assert property (
      $past(rst) |-> cfg.ch1_pwr == ccr_pkg::PWR_DN_HIZ && cfg.ch0_pwr == ccr_pkg::PWR_DN_HIZ
      && cfg.ch2_pwr == 2'h3 && cfg.ch2_down)
      else $error("power modes not high impedance after reset");

   a_ch2_down: assert property (
      cfg_take |=> cfg.ch2_down == ($past(req.wdata[2:1]) != 2'h0))
      else $error("channel 2 power-down flag wrong");

   a_read_answer: assert property (
      req.rd && hit(req.addr, `CCR_ADDR_CFG) |=> rd_valid && rd_data == $past(cfg_r))
      else $error("config readback wrong");

   // whole config word, lock handling, refused and unmapped accesses
   a_cfg_word: assert property (
      cfg_take |=> cfg_r == $past(req.wdata))
      else $error("config word not taken whole");

   a_ch2_field: assert property (
      cfg_take |=> cfg.ch2_pwr == $past(req.wdata[2:1]))
      else $error("channel 2 power field not written");

   a_cfg_refused: assert property (
      cfg_hit && !wr_ok |=> $stable(cfg_r) && wr_refused)
      else $error("config changed on a refused write");

   a_unmapped_read: assert property (
      req.rd && !map_hit |=> rd_valid && rd_data == 16'h0000)
      else $error("unmapped or trigger read not zero");

   a_trig_taken: assert property (
      trig_hit |=> !wr_refused)
      else $error("trigger write refused");

   a_lock_set: assert property (
      !locked && cfg_take && req.wdata[`CCR_LOCK_BIT] |=> locked && cfg.lock)
      else $error("lock bit write did not lock");

   a_arm_keeps: assert property (
      s_arm |=> locked && cfg.lock)
      else $error("unlock code alone cleared the lock");

   a_armed_relock: assert property (
      s_arm ##1 s_relock |=> cfg.lock && wr_refused)
      else $error("armed config write with lock set not refused");

   a_stale_arm: assert property (
      s_arm ##1 s_other_wr ##1 s_clear |=> cfg.lock && wr_refused)
      else $error("arm not dropped by an intervening write");

   a_read_hold: assert property (
      !req.rd |=> $stable(rd_data))
      else $error("read data changed without a read");

   a_unmapped_write: assert property (
      req.wr && !map_hit && !trig_hit |=> wr_refused)
      else $error("unmapped write not flagged");

endmodule // ccr_cfg_regs

/* testbench/ccr_host.sv */
// host model issuing register accesses to the code and config bank
`timescale 1ns/100ps
`include "ccr_regs.svh"
module ccr_host
(
   // clock
   input wire logic ref_clk,
   // register port
   output ccr_pkg::ccr_req_t req,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   input wire logic wr_refused
);
   logic [15:0] rdd;
   logic rdv;
   logic refd;
   // port idle from time zero
   initial req = '0;
   // one request held over its taking edge, answers captured the cycle after
   task xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
      req = '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge ref_clk);
      #1;
      rdd = rd_data;
      rdv = rd_valid;
      refd = wr_refused;
   endtask
   // release the port for one cycle
   task idle();
      req = '0;
      @(posedge ref_clk);
      #1;
   endtask
   // config word with the reserved bits kept at ones
   function automatic logic [15:0] cfg_word(input logic [3:0] top, input logic [1:0] p1, p0, p2);
      cfg_word = {top, p1, 1'b1, p0, 4'hF, p2, 1'b1};
   endfunction
   // password write then the clearing config write, back to back
   task unlock(input logic [3:0] code, input logic [15:0] cfgw);
      xfer(1'b1, `CCR_ADDR_TRIG, {code, 12'h000});
      xfer(1'b1, `CCR_ADDR_CFG, cfgw);
   endtask
endmodule // ccr_host

/* testbench/testbench.sv */
// self-checking bench for the code and config register bank
`timescale 1ns/100ps
`include "ccr_regs.svh"
module testbench;
   logic ref_clk;
   logic rst;
   ccr_pkg::ccr_req_t req;
   logic [15:0] rd_data;
   logic rd_valid;
   logic wr_refused;
   logic [2:0][9:0] chan_code;
   ccr_pkg::ccr_cfg_t cfg;
   int err_count;
   int comparisons;
   logic [7:0] addrs [3] = '{`CCR_ADDR_CH0, `CCR_ADDR_CH1, `CCR_ADDR_CH2};
   logic [15:0] words [3] = '{16'hABCF, 16'hFFFF, 16'h5A5F};
   // design under test and its host
   ccr_cfg_regs DUT (.ref_clk(ref_clk), .rst(rst), .req(req), .rd_data(rd_data),
      .rd_valid(rd_valid), .wr_refused(wr_refused), .chan_code(chan_code), .cfg(cfg));
   ccr_host host (.ref_clk(ref_clk), .req(req), .rd_data(rd_data), .rd_valid(rd_valid),
      .wr_refused(wr_refused));
   // 125 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // compare and count
   task chk(input string name, input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // verdict and end of run
   task conclude();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // config outputs packed back into register layout
   function automatic logic [15:0] cfg_out();
      cfg_out = {cfg.latch_sel, cfg.lock, cfg.fault_sel, cfg.int_ref_en, cfg.ch1_pwr,
         1'b1, cfg.ch0_pwr, 4'hF, cfg.ch2_pwr, 1'b1};
   endfunction
   // reset values at ports and in readback
   task t_reset();
      chk("cfg port", cfg_out(), `CCR_CFG_RST);
      chk("ch2 down", {15'h0, cfg.ch2_down}, 16'h0001);
      host.xfer(1'b0, `CCR_ADDR_CFG, 16'h0000);
      chk("cfg read", host.rdd, `CCR_CFG_RST);
      chk("rd valid", {15'h0, host.rdv}, 16'h0001);
      for (int i = 0; i < 3; i++)
      begin
         host.xfer(1'b0, addrs[i], 16'h0000);
         chk("code read", host.rdd, 16'h0000);
      end
      host.xfer(1'b0, `CCR_ADDR_TRIG, 16'h0000);
      chk("trig read", host.rdd, 16'h0000);
      host.idle();
      $display("test reset done");
   endtask
   // code registers written back to back, low bits ignored
   task t_codes();
      for (int i = 0; i < 3; i++)
         host.xfer(1'b1, addrs[i], words[i]);
      for (int i = 0; i < 3; i++)
      begin
         chk("chan code", {6'h0, chan_code[i]}, {6'h0, words[i][15:6]});
         host.xfer(1'b0, addrs[i], 16'h0000);
         chk("code read", host.rdd, words[i] & 16'hFFF0);
      end
      host.idle();
      $display("test codes done");
   endtask
   // every power mode and each single-bit field other than lock
   task t_cfg();
      logic [1:0] m;
      logic [15:0] w;
      for (int i = 0; i < 4; i++)
      begin
         m = i[1:0];
         w = host.cfg_word({m[0], 1'b0, m[1], m[0]}, m, ~m, m);
         host.xfer(1'b1, `CCR_ADDR_CFG, w);
         chk("cfg port", cfg_out(), w);
         chk("ch2 down", {15'h0, cfg.ch2_down}, {15'h0, m != 2'h0});
         host.xfer(1'b0, `CCR_ADDR_CFG, 16'h0000);
         chk("cfg read", host.rdd, w);
      end
      host.idle();
      $display("test config done");
   endtask
   // lock, refused writes, wrong and right unlock sequences
   task t_lock();
      logic [15:0] lk;
      logic [15:0] clr;
      lk = host.cfg_word(4'h4, 2'h0, 2'h1, 2'h0);
      clr = host.cfg_word(4'h1, 2'h2, 2'h0, 2'h1);
      host.xfer(1'b1, `CCR_ADDR_CFG, lk);
      chk("lock bit", {15'h0, cfg.lock}, 16'h0001);
      host.xfer(1'b1, `CCR_ADDR_CH0, 16'h1230);
      chk("refused", {15'h0, host.refd}, 16'h0001);
      chk("chan code", {6'h0, chan_code[0]}, {6'h0, words[0][15:6]});
      host.xfer(1'b1, `CCR_ADDR_CH2, 16'h0FF0);
      chk("refused", {15'h0, host.refd}, 16'h0001);
      chk("chan code", {6'h0, chan_code[2]}, {6'h0, words[2][15:6]});
      host.xfer(1'b1, `CCR_ADDR_CFG, clr);
      chk("refused", {15'h0, host.refd}, 16'h0001);
      host.unlock(4'h6, clr);
      chk("refused", {15'h0, host.refd}, 16'h0001);
      chk("cfg port", cfg_out(), lk);
      host.unlock(`CCR_UNLOCK_CODE, clr);
      chk("refused", {15'h0, host.refd}, 16'h0000);
      chk("cfg port", cfg_out(), clr);
      host.xfer(1'b1, 8'h00, 16'hFFFF);
      chk("refused", {15'h0, host.refd}, 16'h0001);
      host.idle();
      $display("test lock done");
   endtask
   // watchdog
   initial
   begin
      #100000;
      err_count++;
      conclude();
   end
   // main sequence
   initial
   begin
      rst = 1'b1;
      err_count = 0;
      comparisons = 0;
      repeat (16) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_codes();
      t_cfg();
      t_lock();
      conclude();
   end
endmodule // testbench
